// >>> src/bms_pkg.sv
// constants, types and behaviour summary of the buck mode sequencer
//
// Behaviour
// - enter pulse skipping after low-load flag holds for 32 switching cycles
// - in pulse skipping, start high-side pulse when output below +0.8% trip
// - skip pulse ends at 200 mA peak; rectifier runs to near-zero current
// - keep pulsing until output above +1.6%, then idle until low trip
// - leave pulse skipping at once when output falls 1.6% below nominal
// - soft-start limit steps 200, 400, 800 mA then settles at 1.2 A
// - full duty demand holds high-side switch on without periodic turn-off
// - turn-on pin low shuts everything down except the bandgap while over temperature
// - thermal shutdown keeps bandgap on; restarts when temperature clears
// - turn-on rising starts through soft-start stepping, not full limit
// - undervoltage lockout keeps both switches off
// - without external clock, switch from internal 850 kHz oscillator
// - accept 600 to 1200 kHz external clock, lock from first rising edge
// - no sync edge for four clock cycles starts fallback to internal clock
// - no switching while changing from external to internal clock
// - locked to external clock forces fixed-frequency operation
// - sync pin low: pulse width at heavy load, pulse skipping at light
// - output ok flag low whenever turn-on pin is low
// - output ok flag held low 250 us after enable with supply above 2.7 V
// - after the delay, output ok follows the 98.5% comparator
// - static high sync forces pulse width; static low allows skipping
// - forced pulse width keeps rectifier on through zero current
// - cycle: clock turns switch on, duty or limit trip, dead time, rectifier
package bms_pkg;
    localparam int CLK_MHZ        = 50;
    localparam int CLK_HZ         = CLK_MHZ * 1_000_000;
    localparam int OSC_KHZ        = 850;
    localparam int EXT_MAX_KHZ    = 1200;
    localparam int OSC_DIV        = CLK_HZ / (OSC_KHZ * 1000);
    localparam int EXT_MIN_PER    = CLK_HZ / (EXT_MAX_KHZ * 1000);
    localparam int SYNC_LOSS_PER  = 4;
    localparam int SYNC_LOSS_CYC  = SYNC_LOSS_PER * OSC_DIV;
    localparam int LOAD_LOW_TICKS = 32;
    localparam int SS_STEP_TICKS  = 16;
    localparam int DEAD_NS        = 40;
    localparam int DEAD_CYC       = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int PG_DELAY_US    = 250;
    localparam int PG_DELAY_CYC   = PG_DELAY_US * CLK_MHZ;

    localparam logic [1:0] ILIM_200MA  = 2'h0;
    localparam logic [1:0] ILIM_400MA  = 2'h1;
    localparam logic [1:0] ILIM_800MA  = 2'h2;
    localparam logic [1:0] ILIM_1200MA = 2'h3;

    localparam int          ADDR_W     = 12;
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STAT   = 12'h004;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_FORCE_PWM = 0;
    localparam int STAT_PFM       = 0;
    localparam int STAT_EXT       = 1;
    localparam int STAT_PG        = 2;
    localparam int STAT_RUN       = 3;
    localparam int STAT_ILIM      = 4;
    localparam int STAT_STATE     = 8;
    localparam int STAT_OT        = 12;
    localparam int STAT_UVLO      = 13;
    localparam int STAT_SWOVER    = 14;

    typedef enum logic [2:0] {
        ST_OFF     = 3'h0,
        ST_IDLE    = 3'h1,
        ST_HS      = 3'h2,
        ST_DEAD_HL = 3'h3,
        ST_LS      = 3'h4,
        ST_DEAD_LH = 3'h5
    } bms_state_e;

    typedef struct packed {
        logic load_low;
        logic skip_low;
        logic skip_high;
        logic mode_return_trip;
        logic duty_trip;
        logic ilim_trip;
        logic peak_trip;
        logic zero_cur;
        logic uvlo;
        logic over_temp;
        logic vin_ok;
        logic out_ok;
    } bms_cmp_s;

    typedef struct packed {
        logic hs_on;
        logic ls_on;
    } bms_gate_s;
endpackage

// >>> src/bms_sync_detect.sv
// switching clock source: internal divider or locked external sync edges
`timescale 1ns/1ps
`default_nettype none
module bms_sync_detect (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic sync_lvl,
    output logic      sw_tick,
    output logic      ext_locked,
    output logic      switchover
);
    import bms_pkg::*;
    localparam int GW = $clog2(SYNC_LOSS_CYC + 1);
    localparam int DW = $clog2(OSC_DIV);

    typedef struct packed {
        logic          prev;
        logic [GW-1:0] gap;
        logic [DW-1:0] div;
        logic          locked;
        logic          swover;
        logic          tick;
    } bms_sd_st_s;

    bms_sd_st_s q, d;
    logic rise;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        d.prev = sync_lvl;
        rise = sync_lvl & ~q.prev;
        if (q.gap != GW'(SYNC_LOSS_CYC))
            d.gap = q.gap + GW'(1);
        if (rise && (!q.locked || q.gap >= GW'(EXT_MIN_PER - 1))) begin
            d.locked = 1'b1;
            d.swover = 1'b0;
            d.gap = '0;
            d.tick = 1'b1;
        end else if (q.locked && q.gap >= GW'(SYNC_LOSS_CYC - 1)) begin
            d.locked = 1'b0;
            d.swover = 1'b1;
            d.div = '0;
        end else if (!q.locked) begin
            if (q.div == DW'(OSC_DIV - 1)) begin
                d.div = '0;
                d.tick = 1'b1;
                d.swover = 1'b0;
            end else begin
                d.div = q.div + DW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

    assign sw_tick = q.tick;
    assign ext_locked = q.locked;
    assign switchover = q.swover;
endmodule // bms_sync_detect
`default_nettype wire

// >>> src/bms_softstart.sv
// soft-start current limit stepper
`timescale 1ns/1ps
`default_nettype none
module bms_softstart #(
    parameter int STEP_TICKS = bms_pkg::SS_STEP_TICKS
) (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       restart,
    input  wire logic       sw_tick,
    output logic [1:0]      ilim_sel
);
    import bms_pkg::*;
    localparam int CW = $clog2(STEP_TICKS + 1);

    typedef struct packed {
        logic [1:0]    level;
        logic [CW-1:0] cnt;
    } bms_ss_st_s;

    bms_ss_st_s q, d;

    always_comb begin
        d = q;
        if (restart) begin
            d.level = ILIM_200MA;
            d.cnt = '0;
        end else if (sw_tick && q.level != ILIM_1200MA) begin
            if (q.cnt == CW'(STEP_TICKS - 1)) begin
                d.cnt = '0;
                d.level = q.level + 2'h1;
            end else begin
                d.cnt = q.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

    assign ilim_sel = q.level;
endmodule // bms_softstart
`default_nettype wire

// >>> src/bms_core.sv
// buck mode sequencer top: mode control, gate sequencing, power good, apb
`timescale 1ns/1ps
`default_nettype none
module bms_core #(
    parameter int PG_DELAY_CYCLES = bms_pkg::PG_DELAY_CYC,
    parameter int SS_STEPS        = bms_pkg::SS_STEP_TICKS
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  turn_on_pin,
    input  wire logic                  mode_sync_input,
    input  wire bms_pkg::bms_cmp_s     cmp,
    output bms_pkg::bms_gate_s         gate,
    output logic [1:0]                 ilim_sel,
    output logic                       bandgap_en,
    output logic                       osc_en,
    output logic                       output_ok_flag,
    output logic                       output_ok_oe,
    input  wire logic [11:0]           paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr
);
    import bms_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    localparam int IW = 14;
    localparam int PW = $clog2(PG_DELAY_CYCLES + 1);
    localparam int LW = $clog2(LOAD_LOW_TICKS + 1);
    localparam int DW = $clog2(DEAD_CYC + 1);

    typedef struct packed {
        logic [IW-1:0] s1;
        logic [IW-1:0] s2;
        bms_state_e    st;
        logic          pulse_skip_modulation;
        logic [LW-1:0] low_cnt;
        logic [DW-1:0] dead_cnt;
        logic          run;
        logic          ss_restart;
        logic [PW-1:0] pg_cnt;
        logic          pg;
        logic          hs;
        logic          ls;
        logic          bg;
        logic          osc;
        logic          force_pwm;
        logic [31:0]   rdata;
    } bms_core_st_s;

    bms_core_st_s q, d;

    logic       en;
    logic       sync_lvl;
    bms_cmp_s   c;
    logic       sw_tick;
    logic       ext_locked;
    logic       switchover;
    logic [1:0] ss_level;
    logic       forced;
    logic       run_now;
    logic       dead_done;
    logic       apb_setup;
    logic       apb_access;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == REG_CTRL) || (a == REG_STAT);
    endfunction

    function automatic logic [31:0] stat_word(input bms_core_st_s s,
                                             input logic lk,
                                             input logic sw,
                                             input logic [1:0] lv);
        logic [31:0] w;
        w = '0;
        w[STAT_PFM] = s.pulse_skip_modulation;
        w[STAT_EXT] = lk;
        w[STAT_PG] = s.pg;
        w[STAT_RUN] = s.run;
        w[STAT_ILIM +: 2] = lv;
        w[STAT_STATE +: 3] = s.st;
        w[STAT_OT] = s.s2[2];
        w[STAT_UVLO] = s.s2[3];
        w[STAT_SWOVER] = sw;
        stat_word = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // synchronised inputs

    assign en = q.s2[IW-1];
    assign sync_lvl = q.s2[IW-2];
    assign c = bms_cmp_s'(q.s2[IW-3:0]);

    bms_sync_detect u_sync (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .sync_lvl   (sync_lvl),
        .sw_tick    (sw_tick),
        .ext_locked (ext_locked),
        .switchover (switchover)
    );

    bms_softstart #(
        .STEP_TICKS (SS_STEPS)
    ) u_ss (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .restart  (q.ss_restart),
        .sw_tick  (sw_tick),
        .ilim_sel (ss_level)
    );

    // static high, locked clock or software force
    assign forced = sync_lvl | ext_locked | q.force_pwm;
    assign run_now = en & ~c.over_temp & ~c.uvlo;
    assign dead_done = (q.dead_cnt == DW'(DEAD_CYC - 1));
    assign apb_setup = psel & ~penable;
    assign apb_access = psel & penable;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        d.s1 = {turn_on_pin, mode_sync_input, cmp};
        d.s2 = q.s1;
        d.run = run_now;
        d.ss_restart = run_now & ~q.run;
        d.dead_cnt = dead_done ? q.dead_cnt : q.dead_cnt + DW'(1);

        if (!c.load_low) begin
            d.low_cnt = '0;
        end else if (sw_tick && q.low_cnt != LW'(LOAD_LOW_TICKS)) begin
            d.low_cnt = q.low_cnt + LW'(1);
        end
        if (!q.pulse_skip_modulation && !forced && q.low_cnt == LW'(LOAD_LOW_TICKS))
            d.pulse_skip_modulation = 1'b1;
        if (q.pulse_skip_modulation && c.mode_return_trip) begin
            d.pulse_skip_modulation = 1'b0;
            d.low_cnt = '0;
        end
        if (forced || !run_now) begin
            d.pulse_skip_modulation = 1'b0;
            d.low_cnt = '0;
        end

        case (q.st)
            ST_OFF: begin
                if (run_now)
                    d.st = ST_IDLE;
            end
            ST_IDLE: begin
                if (q.pulse_skip_modulation && c.skip_low) begin
                    d.st = ST_DEAD_LH;
                    d.dead_cnt = '0;
                end else if (!q.pulse_skip_modulation && sw_tick) begin
                    d.st = ST_DEAD_LH;
                    d.dead_cnt = '0;
                end
            end
            ST_HS: begin
                if (q.pulse_skip_modulation && c.peak_trip) begin
                    d.st = ST_DEAD_HL;
                    d.dead_cnt = '0;
                // trip ends on-time, else stays on
                end else if (!q.pulse_skip_modulation && (c.duty_trip || c.ilim_trip)) begin
                    d.st = ST_DEAD_HL;
                    d.dead_cnt = '0;
                end
            end
            ST_DEAD_HL: begin
                if (dead_done)
                    d.st = ST_LS;
            end
            ST_LS: begin
                if (q.pulse_skip_modulation) begin
                    if (c.zero_cur) begin
                        d.st = c.skip_high ? ST_IDLE : ST_DEAD_LH;
                        d.dead_cnt = '0;
                    end
                end else if (sw_tick) begin
                    d.st = ST_DEAD_LH;
                    d.dead_cnt = '0;
                end else if (c.zero_cur && !forced) begin
                    d.st = ST_IDLE;
                end
            end
            ST_DEAD_LH: begin
                if (dead_done)
                    d.st = ST_HS;
            end
            default: begin
                d.st = ST_OFF;
            end
        endcase

        if (switchover && q.st != ST_OFF)
            d.st = ST_IDLE;
        if (!run_now)
            d.st = ST_OFF;

        // gate drive from next state only
        d.hs = (d.st == ST_HS);
        d.ls = (d.st == ST_LS);

        d.bg = en | c.over_temp;
        d.osc = en;

        if (!en) begin
            d.pg_cnt = '0;
            d.pg = 1'b0;
        end else begin
            if (c.vin_ok && q.pg_cnt != PW'(PG_DELAY_CYCLES))
                d.pg_cnt = q.pg_cnt + PW'(1);
            d.pg = (q.pg_cnt == PW'(PG_DELAY_CYCLES)) & c.out_ok;
        end

        // register access
        if (apb_access && pwrite && paddr == REG_CTRL)
            d.force_pwm = pwdata[CTRL_FORCE_PWM];
        if (apb_setup && !pwrite) begin
            if (paddr == REG_CTRL)
                d.rdata = {31'h0, q.force_pwm};
            else if (paddr == REG_STAT)
                d.rdata = stat_word(q, ext_locked, switchover, ss_level);
            else
                d.rdata = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.st <= ST_OFF;
            q.force_pwm <= CTRL_RESET[CTRL_FORCE_PWM];
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign gate.hs_on = q.hs;
    assign gate.ls_on = q.ls;
    assign ilim_sel = ss_level;
    assign bandgap_en = q.bg;
    assign osc_en = q.osc;
    assign output_ok_flag = q.pg;
    assign output_ok_oe = ~q.pg;
    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = apb_access & ~reg_hit(paddr);
endmodule // bms_core
`default_nettype wire

// >>> verification/bms_core_assertions.sv
// concurrent checks on the ports of the buck mode sequencer
`timescale 1ns/1ps
`default_nettype none
module bms_core_assertions
    import bms_pkg::*;
#(
    parameter int PG_DELAY_CYCLES = PG_DELAY_CYC
) (
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic              turn_on_pin,
    input wire bms_pkg::bms_cmp_s  cmp,
    input wire bms_pkg::bms_gate_s gate,
    input wire logic [1:0]        ilim_sel,
    input wire logic              bandgap_en,
    input wire logic              osc_en,
    input wire logic              output_ok_flag,
    input wire logic              output_ok_oe
);
    int en_cyc_q;
    // enabled cycles with good supply, saturating at the delay
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) en_cyc_q <= 0;
        else if (!turn_on_pin) en_cyc_q <= 0;
        else if (cmp.vin_ok && en_cyc_q < PG_DELAY_CYCLES)
            en_cyc_q <= en_cyc_q + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_held_off;
        (!turn_on_pin) [*5];
    endsequence
    sequence s_ls_fall;
        gate.ls_on ##1 !gate.ls_on;
    endsequence
    sequence s_hs_fall;
        gate.hs_on ##1 !gate.hs_on;
    endsequence
    a_no_overlap: assert property (!(gate.hs_on && gate.ls_on))
        else $error("switch and rectifier on together");
    a_dead_before_hs: assert property (s_ls_fall |-> !gate.hs_on [*2])
        else $error("short dead time before switch");
    a_dead_before_ls: assert property (s_hs_fall |-> !gate.ls_on [*2])
        else $error("short dead time before rectifier");
    a_shutdown_all: assert property (s_held_off |->
        !gate.hs_on && !gate.ls_on && !osc_en && !output_ok_flag)
        else $error("activity while disabled");
    a_uvlo_gates_off: assert property (cmp.uvlo [*5] |->
        !gate.hs_on && !gate.ls_on)
        else $error("gate on during lockout");
    a_hot_bandgap_on: assert property (cmp.over_temp [*5] |-> bandgap_en)
        else $error("bandgap off while hot");
    a_pg_after_delay: assert property ($rose(output_ok_flag) |->
        en_cyc_q == PG_DELAY_CYCLES)
        else $error("power good before delay");
    a_pg_follows_ok: assert property ((en_cyc_q == PG_DELAY_CYCLES &&
        turn_on_pin && cmp.vin_ok && cmp.out_ok) [*5] |-> output_ok_flag)
        else $error("power good missing");
    a_pg_open_drain: assert property (output_ok_oe == !output_ok_flag)
        else $error("pull-low enable wrong");
    a_ilim_one_step: assert property (ilim_sel != $past(ilim_sel) |->
        ilim_sel == $past(ilim_sel) + 2'h1 || ilim_sel == ILIM_200MA)
        else $error("current limit skipped a step");
    a_start_low_ilim: assert property ($rose(turn_on_pin) &&
        !cmp.uvlo && !cmp.over_temp |-> ##[1:6] ilim_sel == ILIM_200MA)
        else $error("start without soft-start");
endmodule // bms_core_assertions

bind bms_core bms_core_assertions #(
    .PG_DELAY_CYCLES(PG_DELAY_CYCLES)
) u_bms_core_assertions (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .turn_on_pin    (turn_on_pin),
    .cmp            (cmp),
    .gate           (gate),
    .ilim_sel       (ilim_sel),
    .bandgap_en     (bandgap_en),
    .osc_en         (osc_en),
    .output_ok_flag (output_ok_flag),
    .output_ok_oe   (output_ok_oe)
);
`default_nettype wire

// >>> verification/bms_power_stage.sv
// power stage and comparator model at the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module bms_power_stage (
    input  wire logic              sys_clk,
    input  wire bms_pkg::bms_gate_s gate,
    input  wire bms_pkg::bms_cmp_s  env,
    input  wire logic [7:0]        hs_len,
    output bms_pkg::bms_cmp_s       cmp
);
    import bms_pkg::*;
    int hs_cnt = 0;
    int ls_cnt = 0;
    always @(posedge sys_clk) begin
        hs_cnt <= gate.hs_on ? hs_cnt + 1 : 0;
        ls_cnt <= gate.ls_on ? ls_cnt + 1 : 0;
    end
    always_comb begin
        cmp = env;
        // duty trip after on-time, never at zero length
        cmp.duty_trip = hs_len != 8'h00 && hs_cnt >= hs_len;
        cmp.peak_trip = hs_cnt >= 4;
        cmp.zero_cur  = ls_cnt >= 6;
    end
endmodule // bms_power_stage
`default_nettype wire

// >>> verification/bms_core_tb.sv
// self-checking testbench of the buck mode sequencer
`timescale 1ns/1ps
`default_nettype none
module bms_core_tb;
    import bms_pkg::*;
    localparam int PG_DLY = 20;
    localparam int SS_N   = 2;
    logic        sys_clk, rstn, turn_on_pin, mode_sync_input, sync_lvl;
    logic        bandgap_en, osc_en, output_ok_flag, output_ok_oe;
    logic        psel, penable, pwrite, pready, pslverr, err, ext_on;
    bms_cmp_s    env, cmp;
    bms_gate_s   gate;
    logic [1:0]  ilim_sel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  hs_len;
    logic [1:0]  got_q[$];
    int          exp_q[$];
    int          fails, n_compared, cycles, n, sync_cnt;

    bms_core #(.PG_DELAY_CYCLES(PG_DLY), .SS_STEPS(SS_N)) u_bms_core (
        .sys_clk(sys_clk), .rstn(rstn), .turn_on_pin(turn_on_pin),
        .mode_sync_input(mode_sync_input), .cmp(cmp), .gate(gate),
        .ilim_sel(ilim_sel), .bandgap_en(bandgap_en), .osc_en(osc_en),
        .output_ok_flag(output_ok_flag), .output_ok_oe(output_ok_oe),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    bms_power_stage u_bms_power_stage (.sys_clk(sys_clk), .gate(gate),
        .env(env), .hs_len(hs_len), .cmp(cmp));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        sync_cnt <= ext_on ? (sync_cnt + 1) % 58 : 0;
        // external clock close to the internal rate
        mode_sync_input <= ext_on ? sync_cnt < 29 : sync_lvl;
        if (cycles == 30000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: %s seen %0h want %0h", $time, what,
                     seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic stat(input int b, input logic e, input string what);
        apb(1'b0, REG_STAT, 32'h0);
        chk({31'h0, rd[b]}, {31'h0, e}, what);
    endtask
    task automatic count_hs(input int k);
        logic prev;
        n = 0;
        prev = gate.hs_on;
        repeat (k) begin
            @(posedge sys_clk);
            if (gate.hs_on && !prev) n++;
            prev = gate.hs_on;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        turn_on_pin = 1'b0;
        mode_sync_input = 1'b0;
        sync_lvl = 1'b0;
        env = '0;
        hs_len = 8'h08;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        ext_on = 1'b0;
        sync_cnt = 0;
        fails = 0;
        n_compared = 0;
        cycles = 0;
        void'($urandom(32'h63f92ca7));
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, CTRL_RESET, "ctrl reset");
        apb(1'b0, 12'h0f0, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        $display("test registers done");
        env.vin_ok <= 1'b1;
        env.out_ok <= 1'b1;
        turn_on_pin <= 1'b1;
        exp_q = '{0, 1, 2, 3};
        n = 0;
        for (int i = 0; i < 10 * 58 * SS_N && got_q.size() < 4; i++) begin
            @(posedge sys_clk);
            if (got_q.size() == 0 || got_q[$] !== ilim_sel)
                got_q.push_back(ilim_sel);
            if (!output_ok_flag) n++;
        end
        chk(got_q.size(), 4, "limit steps");
        foreach (exp_q[i]) chk(got_q[i], exp_q[i], "limit step");
        chk(n >= PG_DLY && n <= PG_DLY + 4, 1, "pg delay");
        chk(output_ok_flag, 1'b1, "pg high");
        $display("test start-up done");
        env.load_low <= 1'b1;
        env.skip_high <= 1'b1;
        repeat (30 * 58) @(posedge sys_clk);
        stat(STAT_PFM, 1'b0, "skip too early");
        repeat (4 * 58) @(posedge sys_clk);
        stat(STAT_PFM, 1'b1, "skip entered");
        count_hs(3 * 58);
        chk(n, 0, "skip idle");
        env.skip_high <= 1'b0;
        env.skip_low <= 1'b1;
        count_hs(2 * 58);
        chk(n > 2, 1, "skip pulses");
        env.mode_return_trip <= 1'b1;
        repeat (6) @(posedge sys_clk);
        stat(STAT_PFM, 1'b0, "skip left");
        env.mode_return_trip <= 1'b0;
        repeat (34 * 58) @(posedge sys_clk);
        stat(STAT_PFM, 1'b1, "skip again");
        sync_lvl <= 1'b1;
        repeat (6) @(posedge sys_clk);
        stat(STAT_PFM, 1'b0, "static high forced");
        // a static high looks like a first sync edge: wait out the fallback
        repeat (300) @(posedge sys_clk);
        stat(STAT_EXT, 1'b0, "static high fallback");
        $display("test skip mode done");
        hs_len <= 8'($urandom_range(30, 3));
        count_hs(4 * 58);
        chk(n >= 3, 1, "one pulse per tick");
        hs_len <= 8'h00;
        count_hs(4 * 58);
        chk(n <= 1 && gate.hs_on, 1, "full duty");
        hs_len <= 8'h08;
        sync_lvl <= 1'b0;
        ext_on <= 1'b1;
        repeat (10 * 58) @(posedge sys_clk);
        stat(STAT_EXT, 1'b1, "locked");
        stat(STAT_PFM, 1'b0, "locked forced");
        ext_on <= 1'b0;
        repeat (150) @(posedge sys_clk);
        stat(STAT_EXT, 1'b1, "still locked");
        n = 0;
        for (int i = 0; i < 60; i++) begin
            apb(1'b0, REG_STAT, 32'h0);
            if (rd[STAT_SWOVER] === 1'b1) begin
                n++;
                chk(gate, 2'b00, "gates in switchover");
            end
        end
        chk(n > 0, 1, "switchover seen");
        stat(STAT_EXT, 1'b0, "unlocked");
        apb(1'b1, REG_CTRL, 32'h1);
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h1, "ctrl write");
        $display("test clock source done");
        env.uvlo <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk(gate, 2'b00, "lockout gates");
        env.uvlo <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk(ilim_sel, ILIM_200MA, "restart soft-start");
        env.over_temp <= 1'b1;
        turn_on_pin <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk(bandgap_en, 1'b1, "hot bandgap");
        chk({osc_en, output_ok_flag}, 2'b00, "shutdown");
        env.over_temp <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk(bandgap_en, 1'b0, "bandgap off");
        $display("test protection done");
        end_of_test();
    end
endmodule // bms_core_tb
`default_nettype wire
